/* ptit_regs.svh */
`ifndef PTIT_REGS_SVH
`define PTIT_REGS_SVH

// Register indices and their byte addresses (four times the index).
`define PTIT_CTL_IDX 8'h3C
`define PTIT_CNT_IDX 8'h3D
`define PTIT_EVT_IDX 8'h3E
`define PTIT_MSK_IDX 8'h3F
`define PTIT_CTL_ADDR 8'hF0
`define PTIT_CNT_ADDR 8'hF4
`define PTIT_EVT_ADDR 8'hF8
`define PTIT_MSK_ADDR 8'hFC

// Control register field positions.
`define PTIT_FLAG_BIT 7
`define PTIT_FRZ_BIT 6
`define PTIT_WMASK_BIT 5
`define PTIT_SWAI_BIT 4
`define PTIT_RSTP_BIT 3
`define PTIT_IE_BIT 2

// Event status bits: timeout and refused write.
`define PTIT_EVT_TMO 0
`define PTIT_EVT_REF 1

// Reset values and prescaler terminal counts.
`define PTIT_CTL_RST 8'h00
`define PTIT_CNT_RST 8'h00
`define PTIT_TERM_1 8'h00
`define PTIT_TERM_16 8'h0F
`define PTIT_TERM_256 8'hFF

// Write lock lengths: reference clock edges, then bus cycles.
`define PTIT_LOCK_REF 2'h3
`define PTIT_LOCK_BUS 2'h2
`endif

/* ptit_pkg.sv */
package ptit_pkg;
  // Prescaler rate select codes.
  typedef enum logic [1:0] {
    PTIT_RATE_OFF = 2'h0,
    PTIT_RATE_1 = 2'h1,
    PTIT_RATE_16 = 2'h2,
    PTIT_RATE_256 = 2'h3
  } ptit_rate_t;

  // Bus slave states, one-hot.
  typedef enum logic [1:0] {
    PTIT_IDLE = 2'b01,
    PTIT_ACK = 2'b10
  } ptit_bus_t;
endpackage

/* ptit_timer.sv */
`timescale 1ns/10ps
`include "ptit_regs.svh"

module ptit_timer
  import ptit_pkg::*;
(
  input wire logic clk_i,                // Bus clock, 40 MHz.
  input wire logic arst_n_i,             // Asynchronous reset, active low.
  input wire logic [7:0] address_i,      // Avalon byte address.
  input wire logic read_i,               // Avalon read request.
  input wire logic write_i,              // Avalon write request.
  input wire logic [31:0] writedata_i,   // Avalon write data.
  input wire logic [3:0] byteenable_i,   // Avalon byte enables.
  output logic [31:0] readdata_o,        // Avalon read data.
  output logic waitrequest_o,            // Avalon wait request.
  input wire logic ref_clk_i,            // Internal reference clock, sampled.
  input wire logic special_mode_i,       // High in special modes.
  input wire logic wait_mode_i,          // High while in Wait mode.
  input wire logic stop_mode_i,          // High while in Stop mode.
  input wire logic debug_active_i,       // High while background debug mode is active.
  output logic tick_req_o,               // Timeout interrupt request.
  output logic irq_o                     // Unmasked event status interrupt.
);

  // Bus slave state and answer data.
  ptit_bus_t bus_reg;
  ptit_bus_t bus_next;
  logic [31:0] rdata_reg;

  // Control register fields.
  logic flag_reg;                        // Timeout flag.
  logic frz_reg;                         // Debug freeze bit.
  logic swai_reg;                        // Wait-stop bit.
  logic rstp_reg;                        // Stop-run bit.
  logic ie_reg;                          // Interrupt enable.
  logic [1:0] rt_reg;                    // Prescaler rate select.
  logic once_reg;                        // Write-once chance consumed.
  logic [7:0] cnt_reg;                   // Count select register.

  // Event status and mask registers.
  logic [1:0] evt_reg;
  logic [1:0] msk_reg;

  // Reference clock synchroniser and edge detector.
  logic ref_s1_reg;
  logic ref_s2_reg;
  logic ref_s3_reg;
  logic ref_tick;

  // Counter domain state.
  logic [7:0] pre_reg;                   // Prescaler.
  logic [7:0] dc_reg;                    // Modulus down counter.
  logic [1:0] act_rt_reg;                // Rate code in use.
  logic [7:0] act_cnt_reg;               // Count in use.
  logic off_reg;                         // Counter was off.

  // Write locks: index 0 is count select, index 1 is rate field.
  logic [1:0] lk_ref_reg [2];
  logic [1:0] lk_bus_reg [2];
  logic [1:0] lk_start;
  logic [1:0] locked;

  // Decoded bus access.
  wire req = read_i | write_i;
  wire taken = req & (bus_reg == PTIT_ACK);
  wire wr_en = taken & write_i & byteenable_i[0];
  wire rd_en = taken & read_i;
  wire sel_ctl = (address_i == `PTIT_CTL_ADDR);
  wire sel_cnt = (address_i == `PTIT_CNT_ADDR);
  wire sel_evt = (address_i == `PTIT_EVT_ADDR);
  wire sel_msk = (address_i == `PTIT_MSK_ADDR);
  wire wr_ctl = wr_en & sel_ctl;
  wire wr_cnt = wr_en & sel_cnt;
  wire [7:0] wd = writedata_i[7:0];
  wire wmask = wd[`PTIT_WMASK_BIT];
  wire ctl_open = wr_ctl & ~wmask;

  // Per-bit write acceptance.
  wire once_ok = special_mode_i | ~once_reg;
  wire rt_wr = ctl_open & ~locked[1];
  wire cnt_wr = wr_cnt & ~locked[0];
  wire refused = (ctl_open & locked[1]) | (wr_cnt & locked[0]);

  // Control register read image, write mask reads zero.
  wire [7:0] ctl_img = {flag_reg, frz_reg, 1'b0, swai_reg, rstp_reg, ie_reg, rt_reg};

  // Counter decisions.
  wire off_now = (rt_reg == PTIT_RATE_OFF) | ((rt_reg == PTIT_RATE_1) & (cnt_reg == 8'h00));
  wire wait_init = wait_mode_i & swai_reg;
  wire halt = (stop_mode_i & ~rstp_reg) | (debug_active_i & frz_reg);
  wire run = ~off_now & ~wait_init & ~halt;
  wire [7:0] term = (act_rt_reg == PTIT_RATE_256) ? `PTIT_TERM_256 :
                    (act_rt_reg == PTIT_RATE_16) ? `PTIT_TERM_16 : `PTIT_TERM_1;
  wire pre_end = (pre_reg == term);
  wire period_end = run & ~off_reg & ref_tick & pre_end & (dc_reg == 8'h00);

  // The next bus state follows a simple two-step answer.
  always_comb begin
    unique case (bus_reg)
      PTIT_IDLE: bus_next = req ? PTIT_ACK : PTIT_IDLE;
      PTIT_ACK: bus_next = PTIT_IDLE;
      default: bus_next = PTIT_IDLE;
    endcase
  end

  // Handshake and outputs.
  assign waitrequest_o = req & (bus_reg != PTIT_ACK);
  assign readdata_o = rdata_reg;
  assign tick_req_o = flag_reg & ie_reg;
  assign irq_o = |(evt_reg & msk_reg);
  assign ref_tick = ref_s2_reg & ~ref_s3_reg;
  assign lk_start = {rt_wr, cnt_wr};

  // Bus state register.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_reg <= PTIT_IDLE;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // Read data is captured one edge before the taking edge so it stands there.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (read_i && bus_reg == PTIT_IDLE) begin
      rdata_reg <= {24'h00_0000, sel_ctl ? ctl_img :
                   sel_cnt ? cnt_reg :
                   sel_evt ? {6'h00, evt_reg} :
                   sel_msk ? {6'h00, msk_reg} : 8'h00};
    end
  end

  // Reference clock synchroniser; only the second stage reads the first.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_s3_reg <= 1'b0;
    end else begin
      ref_s1_reg <= ref_clk_i;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
    end
  end

  // Timeout flag: set at period end wins over a clearing write.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_reg <= 1'b0;
    end else if (period_end) begin
      flag_reg <= 1'b1;
    end else if (ctl_open && wd[`PTIT_FLAG_BIT]) begin
      flag_reg <= 1'b0;
    end
  end

  // Freeze bit: any value in special modes, only set in normal modes.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frz_reg <= 1'b0;
    end else if (wr_ctl) begin
      frz_reg <= special_mode_i ? wd[`PTIT_FRZ_BIT] : (frz_reg | wd[`PTIT_FRZ_BIT]);
    end
  end

  // Wait-stop and stop-run bits share one write-once chance in normal modes.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      swai_reg <= 1'b0;
      rstp_reg <= 1'b0;
      once_reg <= 1'b0;
    end else if (ctl_open && once_ok) begin
      swai_reg <= wd[`PTIT_SWAI_BIT];
      rstp_reg <= wd[`PTIT_RSTP_BIT];
      once_reg <= 1'b1;
    end
  end

  // Interrupt enable is free to change on every unmasked write.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ie_reg <= 1'b0;
    end else if (ctl_open) begin
      ie_reg <= wd[`PTIT_IE_BIT];
    end
  end

  // Rate field and count select take writes only while unlocked.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rt_reg <= 2'h0;
      cnt_reg <= `PTIT_CNT_RST;
    end else begin
      if (rt_wr) begin
        rt_reg <= wd[1:0];
      end
      if (cnt_wr) begin
        cnt_reg <= wd;
      end
    end
  end

  // Locks: three reference edges, then two bus cycles.
  for (genvar i = 0; i < 2; i++) begin : g_lock
    assign locked[i] = (lk_ref_reg[i] != 2'h0) | (lk_bus_reg[i] != 2'h0);

    // Each lock restarts on an accepted write and then runs down.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        lk_ref_reg[i] <= 2'h0;
        lk_bus_reg[i] <= 2'h0;
      end else if (lk_start[i]) begin
        lk_ref_reg[i] <= `PTIT_LOCK_REF;
        lk_bus_reg[i] <= `PTIT_LOCK_BUS;
      end else if (lk_ref_reg[i] != 2'h0) begin
        if (ref_tick) begin
          lk_ref_reg[i] <= lk_ref_reg[i] - 2'h1;
        end
      end else if (lk_bus_reg[i] != 2'h0) begin
        lk_bus_reg[i] <= lk_bus_reg[i] - 2'h1;
      end
    end
  end

  // Event status: hardware set wins over the clearing read.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      evt_reg <= 2'h0;
    end else begin
      evt_reg <= ((rd_en && sel_evt) ? 2'h0 : evt_reg) | {refused, period_end};
    end
  end

  // Event mask register.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      msk_reg <= 2'h0;
    end else if (wr_en && sel_msk) begin
      msk_reg <= wd[1:0];
    end
  end

  // Prescaler and modulus down counter.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_reg <= 8'h00;
      dc_reg <= 8'h00;
      act_rt_reg <= 2'h0;
      act_cnt_reg <= 8'h00;
      off_reg <= 1'b1;
    end else if (off_now) begin
      off_reg <= 1'b1;
    end else if (off_reg) begin
      // Leaving off starts a full period straight away.
      off_reg <= 1'b0;
      pre_reg <= 8'h00;
      dc_reg <= cnt_reg;
      act_rt_reg <= rt_reg;
      act_cnt_reg <= cnt_reg;
    end else if (wait_init) begin
      pre_reg <= 8'h00;
      dc_reg <= act_cnt_reg;
    end else if (run && ref_tick) begin
      // Frozen modes never come here, as run is low, and leave the count untouched.
      if (!pre_end) begin
        pre_reg <= pre_reg + 8'h01;
      end else if (dc_reg != 8'h00) begin
        pre_reg <= 8'h00;
        dc_reg <= dc_reg - 8'h01;
      end else begin
        // Period end: pick up the latest rate and restart with no gap.
        pre_reg <= 8'h00;
        dc_reg <= cnt_reg;
        act_rt_reg <= rt_reg;
        act_cnt_reg <= cnt_reg;
      end
    end
  end

  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_req_new;
    req && bus_reg == PTIT_IDLE;
  endsequence

  sequence s_answer;
    waitrequest_o ##1 !waitrequest_o;
  endsequence

  a_bus_answer: assert property (s_req_new |-> s_answer)
    else $error("Bus answer not given on the second cycle.");

  a_flag_on_end: assert property (period_end |=> flag_reg)
    else $error("Timeout flag not set at period end.");

  a_req_gated: assert property (!ie_reg |-> !tick_req_o)
    else $error("Request raised while enable is clear.");

  a_off_holds: assert property ((rt_reg == PTIT_RATE_OFF) [*2] |-> $stable(dc_reg) && $stable(pre_reg))
    else $error("Counter moved while rate field is zero.");

  a_mask_keeps: assert property (wr_ctl && wmask |=> $stable(ie_reg) && $stable(rt_reg) && $stable(swai_reg))
    else $error("Masked write changed protected bits.");

  a_once_only: assert property (wr_ctl && !special_mode_i && once_reg |=> $stable(rstp_reg) && $stable(swai_reg))
    else $error("Write-once bit changed twice in normal mode.");

  a_frz_noclr: assert property (frz_reg && !special_mode_i |=> frz_reg)
    else $error("Freeze bit cleared in normal mode.");

  a_lock_ignore: assert property (wr_cnt && locked[0] |=> $stable(cnt_reg))
    else $error("Count select written while locked.");

  a_wait_reinit: assert property (!off_reg && !off_now && wait_init |=> pre_reg == 8'h00 && dc_reg == $past(act_cnt_reg))
    else $error("Wait entry did not reinitialise the counter.");

  a_freeze_halt: assert property (run == 1'b0 && !off_now && !wait_init && !off_reg |=> $stable(dc_reg))
    else $error("Counter moved while frozen.");

  a_bit5_zero: assert property (!rdata_reg[`PTIT_WMASK_BIT] || !sel_ctl || bus_reg != PTIT_ACK)
    else $error("Write mask bit read back as one.");

endmodule

/* tb.sv */
`timescale 1ns/10ps
`include "ptit_regs.svh"

module tb;
  import ptit_pkg::*;
  // One ordinary case: write a byte to an address, then expect its read-back.
  typedef struct {logic [7:0] a; logic [7:0] d; logic [31:0] e;} ptit_row_t;
  logic clk_i = 1'b0;                  // Bus clock, 25 ns period.
  logic arst_n_i = 1'b0;               // Reset, held low at start.
  logic [7:0] address_i = 8'h00;       // Bus address.
  logic read_i = 1'b0;                 // Bus read request.
  logic write_i = 1'b0;                // Bus write request.
  logic [31:0] writedata_i = 32'h0;    // Bus write data.
  logic [3:0] byteenable_i = 4'h0;     // Bus byte enables.
  logic [31:0] readdata_o;             // Bus read data.
  logic waitrequest_o;                 // Bus wait request.
  logic ref_clk_i = 1'b0;              // Reference clock, eight bus cycles long.
  logic special_mode_i = 1'b1;         // Special mode select.
  logic wait_mode_i = 1'b0;            // Wait mode indication.
  logic stop_mode_i = 1'b0;            // Stop mode indication.
  logic debug_active_i = 1'b0;         // Debug mode indication.
  logic tick_req_o;                    // Timeout request.
  logic irq_o;                         // Event interrupt.
  logic [2:0] ref_div = 3'h0;          // Divider that shapes the reference clock.
  int ref_edges = 0;                   // Rising reference edges so far.
  int fail_count = 0;                  // Mismatches seen.
  int samples_checked = 0;             // Comparisons made.
  int t1;                              // Reference edge of a first tick.
  logic [31:0] rd;                     // Last value read.
  ptit_row_t rows [6] = '{
    '{`PTIT_CTL_ADDR, 8'h7C, 32'h40},  // Masked write: only freeze lands.
    '{`PTIT_CTL_ADDR, 8'h1C, 32'h1C},  // Special mode: freeze clears.
    '{`PTIT_CTL_ADDR, 8'h00, 32'h00},  // Special mode: write-once bits clear again.
    '{`PTIT_CNT_ADDR, 8'h05, 32'h05},  // Count select of five.
    '{`PTIT_MSK_ADDR, 8'h01, 32'h01},  // Unmask the timeout event only.
    '{8'h10, 8'hAA, 32'h00}};          // Unmapped place reads zero.

  ptit_timer u_ptit_timer (.clk_i(clk_i), .arst_n_i(arst_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .ref_clk_i(ref_clk_i), .special_mode_i(special_mode_i), .wait_mode_i(wait_mode_i),
    .stop_mode_i(stop_mode_i), .debug_active_i(debug_active_i), .tick_req_o(tick_req_o),
    .irq_o(irq_o));

  // The clock toggles every half period.
  always #12.5 clk_i = ~clk_i;

  // The reference clock is the bus clock divided by eight, and its rises are counted.
  always @(posedge clk_i) begin
    ref_div <= ref_div + 3'h1;
    ref_clk_i <= ref_div[2];
    if (ref_div == 3'h3) begin
      ref_edges <= ref_edges + 1;
    end
  end

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus cycle; the request is held until the edge where waitrequest is low.
  // Waitrequest and read data are looked at on the rising edge itself, before it updates them.
  task automatic bus(input logic rd_n_wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= {24'h0, d};
    byteenable_i <= 4'hF;
    read_i <= rd_n_wr;
    write_i <= ~rd_n_wr;
    @(posedge clk_i);
    while (waitrequest_o !== 1'b0) begin
      @(posedge clk_i);
    end
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask

  // Reads a register and compares it.
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b1, a, 8'h00);
    check(name, rd, exp);
  endtask

  // Waits for the timeout request, with a bound, and checks that it came.
  task automatic wait_tick();
    int n;
    n = 0;
    @(negedge clk_i);
    while (tick_req_o !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    check("tick", {31'h0, tick_req_o}, 32'h1);
  endtask

  // Applies reset for five cycles.
  task automatic do_reset();
    arst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected length of the run.
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    final_report();
  end

  // Main sequence.
  initial begin
    do_reset();
    rchk("ctl_rst", `PTIT_CTL_ADDR, 32'h0);
    rchk("cnt_rst", `PTIT_CNT_ADDR, 32'h0);
    rchk("evt_rst", `PTIT_EVT_ADDR, 32'h0);
    check("req_rst", {31'h0, tick_req_o}, 32'h0);
    // Ordinary register cases from the table.
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, rows[i].d);
      rchk("row", rows[i].a, rows[i].e);
    end
    repeat (40) @(posedge clk_i);
    // Start from off with rate one and count five: a full six-edge period.
    bus(1'b0, `PTIT_CTL_ADDR, 8'h05);
    repeat (32) @(posedge clk_i);
    rchk("no_early_flag", `PTIT_CTL_ADDR, 32'h05);
    wait_tick();
    t1 = ref_edges;
    check("irq_set", {31'h0, irq_o}, 32'h1);
    bus(1'b0, `PTIT_CTL_ADDR, 8'h85);
    wait_tick();
    check("period", 32'(ref_edges - t1), 32'd6);
    // The third table row wrote the control register inside the rate lock, so bit 1 is set too.
    rchk("evt_read", `PTIT_EVT_ADDR, 32'h3);
    @(negedge clk_i);
    check("irq_clr", {31'h0, irq_o}, 32'h0);
    // Enable off: the flag still sets but no request is made.
    bus(1'b0, `PTIT_CTL_ADDR, 8'h81);
    repeat (80) @(posedge clk_i);
    rchk("ie_off", `PTIT_CTL_ADDR, 32'h81);
    check("req_off", {31'h0, tick_req_o}, 32'h0);
    check("irq_unm", {31'h0, irq_o}, 32'h1);
    bus(1'b0, `PTIT_MSK_ADDR, 8'h00);
    @(negedge clk_i);
    check("irq_msk", {31'h0, irq_o}, 32'h0);
    rchk("evt_tmo", `PTIT_EVT_ADDR, 32'h1);
    // Writing zero keeps the flag; rate zero stops the counter.
    bus(1'b0, `PTIT_CTL_ADDR, 8'h00);
    repeat (40) @(posedge clk_i);
    rchk("w0_keeps", `PTIT_CTL_ADDR, 32'h80);
    bus(1'b0, `PTIT_CTL_ADDR, 8'h80);
    repeat (160) @(posedge clk_i);
    rchk("stopped", `PTIT_CTL_ADDR, 32'h00);
    // Normal mode after a second reset.
    special_mode_i <= 1'b0;
    do_reset();
    bus(1'b0, `PTIT_CTL_ADDR, 8'h38);
    rchk("mask_no_once", `PTIT_CTL_ADDR, 32'h0);
    bus(1'b0, `PTIT_CTL_ADDR, 8'h18);
    bus(1'b0, `PTIT_CTL_ADDR, 8'h04);
    rchk("once", `PTIT_CTL_ADDR, 32'h1C);
    bus(1'b0, `PTIT_CTL_ADDR, 8'h40);
    bus(1'b0, `PTIT_CTL_ADDR, 8'h00);
    rchk("frz_sticky", `PTIT_CTL_ADDR, 32'h58);
    // Count select lock: a second write right after the first is refused.
    bus(1'b0, `PTIT_CNT_ADDR, 8'h01);
    bus(1'b0, `PTIT_CNT_ADDR, 8'h09);
    rchk("cnt_lock", `PTIT_CNT_ADDR, 32'h01);
    rchk("evt_ref", `PTIT_EVT_ADDR, 32'h2);
    repeat (40) @(posedge clk_i);
    // Freeze in debug, stop in wait, run in stop; period is two edges.
    debug_active_i <= 1'b1;
    bus(1'b0, `PTIT_CTL_ADDR, 8'h59);
    repeat (160) @(posedge clk_i);
    rchk("frozen", `PTIT_CTL_ADDR, 32'h59);
    debug_active_i <= 1'b0;
    wait_mode_i <= 1'b1;
    repeat (160) @(posedge clk_i);
    rchk("wait_stop", `PTIT_CTL_ADDR, 32'h59);
    wait_mode_i <= 1'b0;
    stop_mode_i <= 1'b1;
    repeat (80) @(posedge clk_i);
    rchk("stop_run", `PTIT_CTL_ADDR, 32'hD9);
    stop_mode_i <= 1'b0;
    final_report();
  end
endmodule
